// file: src/gating_pkg.sv
// package: register map, field layout and timing for the peripheral clock gating block
package gating_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W = 16;
    // printed offsets are not all multiples of four, so they are indices
    localparam logic [ADDR_W-1:0] IDX_DISABLE_A = 12'h770;
    localparam logic [ADDR_W-1:0] IDX_DISABLE_B = 12'h772;
    localparam logic [REG_W-1:0] RST_DISABLE_A = 16'h0000;
    localparam logic [REG_W-1:0] RST_DISABLE_B = 16'h0000;
    // writable bits of the first register: timers 15..11, others 8..0
    localparam logic [REG_W-1:0] MASK_DISABLE_A = 16'hf9ff;
    localparam logic [REG_W-1:0] MASK_DISABLE_B = 16'hffff;
    localparam int unsigned BIT_TIMER1 = 11;
    localparam int unsigned BIT_CONVERTER = 8;
    localparam int unsigned NUM_TIMERS = 5;
    localparam int unsigned NUM_SERIAL = 9;
    localparam int unsigned NUM_CAPTURE = 8;
    localparam int unsigned NUM_PERIPH = 30;
    // effect latency of a disable bit change, in instruction cycles
    localparam int unsigned GATE_DELAY_CYC = 1;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
endpackage

// file: src/peripheral_gating.sv
// design: per-peripheral clock gating with two disable registers on classic wishbone
//
// Behaviour
// - a set disable bit stops every clock to its peripheral.
// - while disabled, peripheral register writes are dropped and reads flagged invalid.
// - peripheral active only if bit clear and peripheral present in this variant.
// - every present peripheral comes out of reset enabled.
// - setting a disable bit shuts the peripheral off one cycle later.
// - clearing a bit re-enables one cycle later, if its own control requests run.
// - in some variants the converter bit is read/write and reads one when set.
// - first register bits 15..11 disable timers 5..1.
// - first register bits 8..0: converter, twowire, uart2, uart1, spi2, spi1, can2, can1, adc.
// - second register: capture 8..1 in bits 15..8, compare 8..1 in bits 7..0.
// - both disable registers reset to zero.
`timescale 1ns/100ps
module peripheral_gating
    import gating_pkg::*;
#(
    // bit order matches the concatenation {disable_a, disable_b}
    parameter logic [31:0] PRESENT_MASK = 32'hf9ff_ffff,
    parameter bit CONVERTER_READBACK = 1'b1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W+1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // peripheral side, one bit per peripheral in register order
    input wire logic [31:0] periph_run_req_i,
    input wire logic [31:0] periph_wr_i,
    output logic [31:0] periph_clk_en_o,
    output logic [31:0] periph_wr_allow_o,
    output logic [31:0] periph_rd_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [REG_W-1:0] disable_a;
        logic [REG_W-1:0] disable_b;
        logic [31:0] gate_on;
        logic [31:0] rdata;
        logic ack;
    } state_t;

    state_t s_q, s_d;

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [REG_W-1:0] wdat,
                                               input logic [1:0] sel,
                                               input logic [REG_W-1:0] mask);
        logic [REG_W-1:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res & mask;
    endfunction

    // one decode for both registers keeps the read and write paths in step
    function automatic logic hit(input logic [ADDR_W-1:0] idx, input logic [ADDR_W-1:0] target);
        return idx == target;
    endfunction

    logic [ADDR_W-1:0] reg_idx;
    logic req;
    logic [31:0] disables;
    logic [REG_W-1:0] mask_a;

    assign reg_idx = wb_adr_i[ADDR_W+1:2];
    assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign disables = {s_q.disable_a, s_q.disable_b};
    // converter bit only stores where the variant implements it
    assign mask_a = CONVERTER_READBACK ? MASK_DISABLE_A
                                       : (MASK_DISABLE_A & ~(16'h0001 << BIT_CONVERTER));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.rdata = RDATA_UNMAPPED;
        if (req && wb_we_i) begin
            if (hit(reg_idx, IDX_DISABLE_A)) begin
                s_d.disable_a = merge(s_q.disable_a, wb_dat_i[15:0], wb_sel_i[1:0], mask_a);
            end else if (hit(reg_idx, IDX_DISABLE_B)) begin
                s_d.disable_b = merge(s_q.disable_b, wb_dat_i[15:0], wb_sel_i[1:0],
                                      MASK_DISABLE_B);
            end
        end
        if (req && !wb_we_i) begin
            if (hit(reg_idx, IDX_DISABLE_A)) begin
                s_d.rdata = {16'h0000, s_q.disable_a};
            end else if (hit(reg_idx, IDX_DISABLE_B)) begin
                s_d.rdata = {16'h0000, s_q.disable_b};
            end
        end
        // enable follows the stored bit one cycle later, from a flop: no glitches
        s_d.gate_on = ~disables & PRESENT_MASK;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_q.disable_a <= RST_DISABLE_A;
            s_q.disable_b <= RST_DISABLE_B;
            s_q.gate_on <= PRESENT_MASK;
            s_q.rdata <= RDATA_UNMAPPED;
            s_q.ack <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    // clock runs only when gate is on and the peripheral asks to run
    assign periph_clk_en_o = s_q.gate_on & periph_run_req_i;
    assign periph_wr_allow_o = s_q.gate_on & periph_wr_i;
    assign periph_rd_valid_o = s_q.gate_on;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // decoded bus strobes, shared by the assertions below
    logic wr_a;
    logic wr_b;
    logic rd_a;
    logic rd_b;
    assign wr_a = req && wb_we_i && hit(reg_idx, IDX_DISABLE_A);
    assign wr_b = req && wb_we_i && hit(reg_idx, IDX_DISABLE_B);
    assign rd_a = req && !wb_we_i && hit(reg_idx, IDX_DISABLE_A);
    assign rd_b = req && !wb_we_i && hit(reg_idx, IDX_DISABLE_B);

    property p_ack_after_req;
        req |=> wb_ack_o;
    endproperty
    a_ack_after_req: assert property (p_ack_after_req) else $error("request not acked");

    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

    property p_rd_hi_zero;
        wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_rd_hi_zero: assert property (p_rd_hi_zero) else $error("upper read data not zero");

    property p_rd_a;
        rd_a |=> wb_dat_o == {16'h0000, $past(s_q.disable_a)};
    endproperty
    a_rd_a: assert property (p_rd_a) else $error("first register read wrong");

    property p_rd_b;
        rd_b |=> wb_dat_o == {16'h0000, $past(s_q.disable_b)};
    endproperty
    a_rd_b: assert property (p_rd_b) else $error("second register read wrong");

    property p_rd_unmapped;
        (req && !wb_we_i && !rd_a && !rd_b) |=> wb_dat_o == RDATA_UNMAPPED;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == RDATA_UNMAPPED;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    property p_write_b;
        (wr_b && wb_sel_i[0]) |=> s_q.disable_b[7:0] == $past(wb_dat_i[7:0]);
    endproperty
    a_write_b: assert property (p_write_b) else $error("compare bits not stored");

    property p_write_b_hi;
        (wr_b && wb_sel_i[1]) |=> s_q.disable_b[15:8] == $past(wb_dat_i[15:8]);
    endproperty
    a_write_b_hi: assert property (p_write_b_hi) else $error("capture bits not stored");

    property p_keep_a;
        !wr_a |=> $stable(s_q.disable_a);
    endproperty
    a_keep_a: assert property (p_keep_a) else $error("first register moved");

    property p_keep_b;
        !wr_b |=> $stable(s_q.disable_b);
    endproperty
    a_keep_b: assert property (p_keep_b) else $error("second register moved");

    property p_sel_low_a;
        (wr_a && !wb_sel_i[0]) |=> s_q.disable_a[7:0] == $past(s_q.disable_a[7:0]);
    endproperty
    a_sel_low_a: assert property (p_sel_low_a) else $error("unselected byte written");

    property p_sel_hi_b;
        (wr_b && !wb_sel_i[1]) |=> s_q.disable_b[15:8] == $past(s_q.disable_b[15:8]);
    endproperty
    a_sel_hi_b: assert property (p_sel_hi_b) else $error("unselected byte written");

    property p_timer1;
        (wr_a && wb_sel_i[1]) |=> s_q.disable_a[BIT_TIMER1] == $past(wb_dat_i[BIT_TIMER1]);
    endproperty
    a_timer1: assert property (p_timer1) else $error("timer1 bit not stored");

    property p_converter;
        (wr_a && wb_sel_i[1])
            |=> s_q.disable_a[BIT_CONVERTER] == ($past(wb_dat_i[BIT_CONVERTER]) && CONVERTER_READBACK);
    endproperty
    a_converter: assert property (p_converter) else $error("converter bit wrong");

    property p_twowire;
        (wr_a && wb_sel_i[0]) |=> s_q.disable_a[7] == $past(wb_dat_i[7]);
    endproperty
    a_twowire: assert property (p_twowire) else $error("twowire bit not stored");

    property p_uart1;
        (wr_a && wb_sel_i[0]) |=> s_q.disable_a[5] == $past(wb_dat_i[5]);
    endproperty
    a_uart1: assert property (p_uart1) else $error("uart1 bit not stored");

    property p_adc;
        (wr_a && wb_sel_i[0]) |=> s_q.disable_a[0] == $past(wb_dat_i[0]);
    endproperty
    a_adc: assert property (p_adc) else $error("adc bit not stored");

    property p_gate_follow;
        1'b1 |=> s_q.gate_on == (~$past(disables) & PRESENT_MASK);
    endproperty
    a_gate_follow: assert property (p_gate_follow) else $error("gate not one cycle late");

    property p_off_timer5;
        $rose(s_q.disable_a[15]) |=> !periph_rd_valid_o[31];
    endproperty
    a_off_timer5: assert property (p_off_timer5) else $error("timer5 not shut off");

    property p_on_capture;
        $fell(s_q.disable_b[8]) |=> periph_rd_valid_o[8] == PRESENT_MASK[8];
    endproperty
    a_on_capture: assert property (p_on_capture) else $error("capture1 not back on");

    property p_clk_gated_all;
        (periph_clk_en_o & ~s_q.gate_on) == 32'h0000_0000;
    endproperty
    a_clk_gated_all: assert property (p_clk_gated_all) else $error("gated clock runs");

    property p_compare1;
        $rose(s_q.disable_b[0]) |=> !periph_clk_en_o[0];
    endproperty
    a_compare1: assert property (p_compare1) else $error("compare1 still clocked");

    property p_clk_run;
        (periph_clk_en_o & ~periph_run_req_i) == 32'h0000_0000;
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock without run request");

    property p_wr_gated_all;
        (periph_wr_allow_o & ~periph_rd_valid_o) == 32'h0000_0000;
    endproperty
    a_wr_gated_all: assert property (p_wr_gated_all) else $error("write to gated unit");

    property p_absent_all;
        (periph_rd_valid_o & ~PRESENT_MASK) == 32'h0000_0000;
    endproperty
    a_absent_all: assert property (p_absent_all) else $error("absent unit enabled");

    property p_reset_regs;
        $fell(sys_rst_i) |-> (s_q.disable_a == RST_DISABLE_A && s_q.disable_b == RST_DISABLE_B);
    endproperty
    a_reset_regs: assert property (@(posedge core_clk_i) p_reset_regs)
        else $error("registers not zero after reset");

    property p_reset_ack;
        $fell(sys_rst_i) |-> !wb_ack_o;
    endproperty
    a_reset_ack: assert property (@(posedge core_clk_i) p_reset_ack)
        else $error("ack right after reset");

    property p_clk_off;
        !s_q.gate_on[0] |-> !periph_clk_en_o[0];
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock runs while gated");

    property p_wr_block;
        (disables[5] && periph_wr_i[5]) |=> (disables[5] |-> !periph_wr_allow_o[5]);
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write passed to gated unit");

    property p_absent;
        !PRESENT_MASK[25] |-> !periph_clk_en_o[25];
    endproperty
    a_absent: assert property (p_absent) else $error("absent peripheral clocked");

    property p_reset_on;
        $fell(sys_rst_i) |-> periph_rd_valid_o == PRESENT_MASK;
    endproperty
    a_reset_on: assert property (@(posedge core_clk_i) p_reset_on)
        else $error("peripherals not enabled after reset");

    property p_off_delay;
        $rose(disables[3]) |=> !periph_rd_valid_o[3];
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("shutdown latency wrong");

    property p_on_delay;
        ($fell(disables[3]) ##1 periph_run_req_i[3]) |-> periph_clk_en_o[3] == PRESENT_MASK[3];
    endproperty
    a_on_delay: assert property (p_on_delay) else $error("restart latency wrong");

    property p_ack_one;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

    property p_write_a;
        (req && wb_we_i && reg_idx == IDX_DISABLE_A && wb_sel_i[1] && wb_dat_i[15])
            |=> s_q.disable_a[15];
    endproperty
    a_write_a: assert property (p_write_a) else $error("timer5 bit not stored");

    property p_reserved;
        s_q.disable_a[10:9] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("unimplemented bit set");

    property p_gate_stable;
        $stable(disables) |=> $stable(s_q.gate_on);
    endproperty
    a_gate_stable: assert property (p_gate_stable) else $error("gate moved without cause");

    c_write_a: cover property (req && wb_we_i && reg_idx == IDX_DISABLE_A);
    c_read_b: cover property (req && !wb_we_i && reg_idx == IDX_DISABLE_B);
    c_read_a: cover property (rd_a);
    c_unmapped: cover property (req && !wr_a && !wr_b && !rd_a && !rd_b);
    c_gate_cycle: cover property ($fell(s_q.gate_on[20]) ##[1:50] $rose(s_q.gate_on[20]));

endmodule

// file: testbench/periph_model.sv
// far-side model: peripherals that request run and write their own registers
`timescale 1ns/100ps
module periph_model (
    // clock
    input wire logic core_clk_i,
    // which peripherals have their own control set to run
    input wire logic [31:0] run_pat_i,
    // peripheral side
    output logic [31:0] periph_run_req_o,
    output logic [31:0] periph_wr_o
);
    // writes follow a pattern of their own, so the write gate is no copy of the enable
    always_ff @(posedge core_clk_i) begin
        periph_run_req_o <= run_pat_i;
        periph_wr_o <= {run_pat_i[15:0], run_pat_i[31:16]};
    end
endmodule

// file: testbench/peripheral_gating_bench.sv
// bench: register access and per-peripheral gating through the wishbone port
`timescale 1ns/100ps
module peripheral_gating_bench;
    import gating_pkg::*;
    localparam logic [31:0] PRES = 32'hf9ff_ffff;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W+1:0] adr = 14'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] run_pat = 32'hffff_ffff;
    logic [31:0] rdat, dat_o, req, wr, clk_en, wr_ok, rd_ok;
    logic ack;
    int error_cnt = 0;
    int n_checks = 0;
    peripheral_gating #(.PRESENT_MASK(PRES), .CONVERTER_READBACK(1'b1)) peripheral_gating_i (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .periph_run_req_i(req), .periph_wr_i(wr), .periph_clk_en_o(clk_en),
        .periph_wr_allow_o(wr_ok), .periph_rd_valid_o(rd_ok));
    periph_model periph_model_i (.core_clk_i(core_clk_i), .run_pat_i(run_pat),
        .periph_run_req_o(req), .periph_wr_o(wr));
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one classic cycle; read data lands in rdat
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge core_clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        i = 0;
        do begin
            @(posedge core_clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
        if (i >= 20) begin
            error_cnt++;
            final_report();
        end
    endtask
    // gating settles a cycle after the register, so look a few edges later
    task automatic gate(input logic [31:0] dis);
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("clk_en", PRES & ~dis & run_pat, clk_en);
        chk("wr_allow", PRES & ~dis & {run_pat[15:0], run_pat[31:16]}, wr_ok);
        chk("rd_valid", PRES & ~dis, rd_ok);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, 14'h1dc0, 32'h0, 4'h3);
        chk("disable_a", 32'h0, rdat);
        bus(1'b0, 14'h1dc8, 32'h0, 4'h3);
        chk("disable_b", 32'h0, rdat);
        gate(32'h0);
    endtask
    task automatic t_all_off();
        bus(1'b1, 14'h1dc0, 32'hffff_ffff, 4'h3);
        bus(1'b0, 14'h1dc0, 32'h0, 4'h3);
        chk("disable_a", 32'h0000_f9ff, rdat);
        bus(1'b1, 14'h1dc8, 32'h0000_ffff, 4'h3);
        gate(32'hffff_ffff);
    endtask
    task automatic t_bytes();
        run_pat <= 32'h5555_aaaa;
        bus(1'b1, 14'h1dc8, 32'h0, 4'h1);
        bus(1'b1, 14'h1dc0, 32'h0, 4'h2);
        bus(1'b0, 14'h1dc0, 32'h0, 4'h3);
        chk("disable_a", 32'h0000_00ff, rdat);
        bus(1'b0, 14'h1dc8, 32'h0, 4'h3);
        chk("disable_b", 32'h0000_ff00, rdat);
        gate(32'h00ff_ff00);
    endtask
    task automatic t_unmapped();
        bus(1'b1, 14'h1dc4, 32'hffff_ffff, 4'h3);
        bus(1'b0, 14'h1dc4, 32'h0, 4'h3);
        chk("unmapped", 32'h0, rdat);
        bus(1'b0, 14'h1dc0, 32'h0, 4'h3);
        chk("disable_a", 32'h0000_00ff, rdat);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_all_off();
        t_bytes();
        t_unmapped();
        final_report();
    end
endmodule
